// >>> common/lamc_cfg.svh
// Constants for the logic array macrocell block.
// Assumes inclusion by bare name from design and bench files.
`ifndef LAMC_CFG_SVH
`define LAMC_CFG_SVH
`define LAMC_NCELL      8
`define LAMC_NPT        8
`define LAMC_NIN        18
`define LAMC_SIG_W      64
`define LAMC_FIRST_IDX  0
`define LAMC_LAST_IDX   7
`define LAMC_NOFB_LO    3
`define LAMC_NOFB_HI    4
`define LAMC_OE_PT      7
`define LAMC_REG_RESET  1'b0
`endif

// >>> common/lamc_pkg.sv
// Types for the logic array macrocell block.
// Assumes lamc_cfg.svh is on the include path.
`include "lamc_cfg.svh"
package lamc_pkg;
  typedef enum logic [1:0] {
    LAMC_REG_OUT = 2'b00,
    LAMC_COMB_IO = 2'b01,
    LAMC_COMB_OUT = 2'b10,
    LAMC_DED_IN = 2'b11
  } lamc_mode_t;
  typedef logic [`LAMC_NCELL-1:0] lamc_cells_t;
endpackage

// >>> hw/lamc_top.sv
// Eight output macrocells of a sum-of-products array, clocked model.
// Assumes synchronous pins, configuration held static by the programmer.
`timescale 1ns/1ps
`default_nettype none
`include "lamc_cfg.svh"
module lamc_top #(
  parameter int NCELL = `LAMC_NCELL,
  parameter int NPT   = `LAMC_NPT,
  parameter int NIN   = `LAMC_NIN,
  parameter int SIG_W = `LAMC_SIG_W
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // Global and per-cell configuration
  input  wire logic                       register_allow_global,
  input  wire logic                       family_select_global,
  input  wire lamc_pkg::lamc_cells_t      cell_mode_bit,
  input  wire lamc_pkg::lamc_cells_t      cell_polarity_bit,
  // AND array: true and complement masks, one row per term
  input  wire logic [NCELL*NPT*NIN-1:0]   and_true_mask,
  input  wire logic [NCELL*NPT*NIN-1:0]   and_comp_mask,
  // Dedicated inputs: pins 2..9, pin 1 and pin 11
  input  wire logic [NCELL-1:0]           ded_in,
  input  wire logic                       pin1_in,
  input  wire logic                       pin11_oe_n,
  // I/O pins
  input  wire logic [NCELL-1:0]           io_in,
  output logic      [NCELL-1:0]           io_out,
  output logic      [NCELL-1:0]           io_oe,
  // Register preload
  input  wire logic                       preload,
  // Programmer port
  input  wire logic                       prog_erase,
  input  wire logic                       prog_security_set,
  input  wire logic                       prog_sig_we,
  input  wire logic [SIG_W-1:0]           prog_sig_wdata,
  input  wire logic                       prog_verify_rd,
  input  wire logic [$clog2(NCELL*NPT*NIN)-1:0] prog_verify_addr,
  output logic                            verify_data,
  output logic                            security_bit,
  output logic      [SIG_W-1:0]           signature
);
  import lamc_pkg::*;

  localparam int AW = $clog2(NCELL*NPT*NIN);

  // Cell mode from the three bits; unlisted codes fall to dedicated input
  function automatic lamc_mode_t cell_mode(input logic g0, input logic g1,
                                           input logic l0);
    case ({g0, g1, l0})
      3'b010:  cell_mode = LAMC_REG_OUT;
      3'b011:  cell_mode = LAMC_COMB_IO;
      3'b111:  cell_mode = LAMC_COMB_IO;
      3'b100:  cell_mode = LAMC_COMB_OUT;
      3'b101:  cell_mode = LAMC_DED_IN;
      default: cell_mode = LAMC_DED_IN;
    endcase
  endfunction

  // One product term over the array inputs
  function automatic logic pterm(input logic [NIN-1:0] v,
                                 input logic [NIN-1:0] t,
                                 input logic [NIN-1:0] c);
    // Empty term stays high; t and c on one input forces low
    pterm = &((v | ~t) & (~v | ~c));
  endfunction

  logic [NCELL-1:0] q;
  logic [NCELL-1:0] fb;
  logic [NCELL-1:0] sum;
  logic [NCELL-1:0] pt_oe;
  logic [NCELL-1:0] next_q;
  logic [NIN-1:0]   arr_in;
  logic             registered_dev;

  assign registered_dev = ~register_allow_global;

  // Array inputs: eight dedicated pins, then eight feedback lines, then
  // pin 1 and pin 11 as plain inputs in a registered device (clock/OE use)
  assign arr_in = {pin11_oe_n, pin1_in, fb, ded_in};

  // Feedback select per cell
  always_comb begin
    for (int i = 0; i < NCELL; i++) begin
      logic sel;
      lamc_mode_t m;
      sel = family_select_global;
      m = cell_mode(register_allow_global, family_select_global,
                    cell_mode_bit[i]);
      if (i == `LAMC_FIRST_IDX || i == `LAMC_LAST_IDX)
        sel = ~register_allow_global;
      fb[i] = 1'b0;
      case (m)
        LAMC_REG_OUT:  fb[i] = ~q[i];
        LAMC_COMB_IO:  fb[i] = io_in[i];
        LAMC_COMB_OUT, LAMC_DED_IN: begin
          if (!sel) begin
            // End cells carry pin 1 and pin 11 in a non-registered device
            if (i == `LAMC_LAST_IDX)
              fb[i] = pin1_in;
            else if (i == `LAMC_FIRST_IDX)
              fb[i] = pin11_oe_n;
            else if (m == LAMC_DED_IN)
              fb[i] = io_in[i];
            else if (i == `LAMC_NOFB_LO || i == `LAMC_NOFB_HI)
              fb[i] = 1'b0;
            else
              fb[i] = io_out[i];
          end else begin
            fb[i] = io_in[i];
          end
        end
        default: fb[i] = 1'b0;
      endcase
    end
  end

  // OR of product terms and polarity
  always_comb begin
    for (int i = 0; i < NCELL; i++) begin
      logic acc;
      int   base;
      acc = 1'b0;
      base = 0;
      for (int p = 0; p < NPT; p++) begin
        base = ((i * NPT) + p) * NIN;
        if (p != `LAMC_OE_PT ||
            cell_mode(register_allow_global, family_select_global,
                      cell_mode_bit[i]) != LAMC_COMB_IO)
          acc = acc | pterm(arr_in, and_true_mask[base +: NIN],
                            and_comp_mask[base +: NIN]);
      end
      base = ((i * NPT) + `LAMC_OE_PT) * NIN;
      pt_oe[i] = pterm(arr_in, and_true_mask[base +: NIN],
                       and_comp_mask[base +: NIN]);
      // Polarity 0 inverts the sum for an active low output
      sum[i] = acc ^ ~cell_polarity_bit[i];
    end
  end

  // Register next value, preloaded from the pins under test
  always_comb begin
    for (int i = 0; i < NCELL; i++)
      next_q[i] = preload ? ~io_in[i] : ~sum[i];
  end

  // Pin follows ~q, but reset clears io_out to 0 rather than to ~q, so the registered output is low after reset
  always_ff @(posedge clk) begin
    if (rst)
      q <= {NCELL{`LAMC_REG_RESET}};
    else if (registered_dev)
      q <= next_q;
  end

  // Pin drive, registered to keep outputs on flip-flops
  always_ff @(posedge clk) begin
    if (rst) begin
      io_out <= '0;
      io_oe  <= '0;
    end else begin
      for (int i = 0; i < NCELL; i++) begin
        case (cell_mode(register_allow_global, family_select_global,
                        cell_mode_bit[i]))
          LAMC_REG_OUT: begin
            io_out[i] <= ~next_q[i];
            io_oe[i]  <= ~pin11_oe_n & ~preload;
          end
          LAMC_COMB_IO: begin
            io_out[i] <= sum[i];
            io_oe[i]  <= pt_oe[i];
          end
          LAMC_COMB_OUT: begin
            io_out[i] <= sum[i];
            io_oe[i]  <= 1'b1;
          end
          default: begin
            io_out[i] <= 1'b0;
            io_oe[i]  <= 1'b0;
          end
        endcase
      end
    end
  end

  // Security bit: set by programmer, cleared by full erase or by reset
  always_ff @(posedge clk) begin
    if (rst)
      security_bit <= 1'b0;
    else if (prog_security_set)
      security_bit <= 1'b1;
    else if (prog_erase)
      security_bit <= 1'b0;
  end

  // Signature survives security; erase blanks it and leaves the array masks, which are inputs
  always_ff @(posedge clk) begin
    if (rst)
      signature <= '0;
    else if (prog_sig_we)
      signature <= prog_sig_wdata;
    else if (prog_erase)
      signature <= '0;
  end

  // Array read-back, masked once secured
  always_ff @(posedge clk) begin
    if (rst)
      verify_data <= 1'b0;
    else if (prog_verify_rd)
      verify_data <= security_bit ? 1'b0 :
                     and_true_mask[prog_verify_addr[AW-1:0]];
  end
endmodule
`default_nettype wire

// >>> sim/lamc_board.sv
// Board model: returns the I/O pin levels to the block.
// Assumes the same clock as the block.
`timescale 1ns/1ps
`default_nettype none
module lamc_board (
  // Clock
  input  wire logic       clk,
  // Pins
  input  wire logic [7:0] io_out,
  input  wire logic [7:0] io_oe,
  output logic      [7:0] io_in
);
  logic [7:0] last = 8'h00;
  // Released pins toggle so a stale level never passes for a drive
  always_comb io_in = (io_oe & io_out) | (~io_oe & ~last);
  always_ff @(posedge clk) last <= io_in;
endmodule
`default_nettype wire

// >>> sim/lamc_top_asserts.sv
// Checker on the macrocell top: pin enables, security, signature.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module lamc_top_asserts #(
  parameter int NCELL = 8,
  parameter int SIG_W = 64
) (
  // Clock, mode and pins
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  register_allow_global,
  input wire logic                  family_select_global,
  input wire lamc_pkg::lamc_cells_t cell_mode_bit,
  input wire logic                  pin11_oe_n,
  input wire logic                  preload,
  input wire logic [NCELL-1:0]      io_oe,
  // Programmer port
  input wire logic                  prog_erase,
  input wire logic                  prog_security_set,
  input wire logic                  prog_sig_we,
  input wire logic [SIG_W-1:0]      prog_sig_wdata,
  input wire logic                  prog_verify_rd,
  input wire logic                  verify_data,
  input wire logic                  security_bit,
  input wire logic [SIG_W-1:0]      signature
);
  import lamc_pkg::*;
  wire ra = register_allow_global;
  wire fs = family_select_global;
  wire [NCELL-1:0] cm = cell_mode_bit;
  // Preload releases the registered pins so the tester can drive them
  wire [NCELL-1:0] oe_pin = {NCELL{!pin11_oe_n && !preload}};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  unlisted_off_a: assert property (
    !ra && !fs |=> io_oe == '0) else $error("unlisted drives");
  input_off_a: assert property (
    ra && !fs |=> (io_oe & $past(cm)) == '0) else $error("input drives");
  comb_on_a: assert property (
    ra && !fs |=> (io_oe | $past(cm)) == '1) else $error("output off");
  reg_oe_a: assert property (
    !ra && fs |=> ((io_oe ^ $past(oe_pin)) & ~$past(cm)) == '0)
    else $error("reg enable");
  secure_read_a: assert property (
    security_bit && prog_verify_rd |=> !verify_data) else $error("leak");
  secure_hold_a: assert property (
    security_bit && !prog_erase |=> security_bit) else $error("sec lost");
  erase_clear_a: assert property (
    prog_erase && !prog_security_set |=> !security_bit) else $error("erase");
  sig_write_a: assert property (
    prog_sig_we && !prog_erase |=> signature == $past(prog_sig_wdata))
    else $error("sig write");
  sig_keep_a: assert property (
    !prog_sig_we && !prog_erase |=> $stable(signature)) else $error("sig");
  reset_low_a: assert property (disable iff (1'b0)
    rst |=> !security_bit && io_oe == '0) else $error("reset");
  cover property (ra && fs && cm != '0);
  cover property (security_bit && prog_verify_rd);
  cover property (prog_erase && security_bit);
endmodule
bind lamc_top lamc_top_asserts #(.NCELL(NCELL), .SIG_W(SIG_W)) u_asserts (
  .clk, .rst, .register_allow_global, .family_select_global, .cell_mode_bit,
  .pin11_oe_n, .preload, .io_oe, .prog_erase, .prog_security_set, .prog_sig_we,
  .prog_sig_wdata, .prog_verify_rd, .verify_data, .security_bit, .signature);
`default_nettype wire

// >>> sim/test_lamc_top.sv
// Random plus corner bench for the macrocell block.
// Assumes the board model and checker compile alongside.
`timescale 1ns/1ps
`default_nettype none
module test_lamc_top;
  import lamc_pkg::*;
  localparam int NB = 1152;
  localparam logic [2:0] MD [6] = '{3'b010, 3'b100, 3'b111, 3'b011,
                                    3'b101, 3'b000};
  logic clk = 1'b0, rst = 1'b1, ra = 1'b0, fs = 1'b0, p1 = 1'b0;
  logic oen = 1'b0, pre = 1'b0, vd, sb;
  logic [3:0] pg = 4'h0;
  lamc_cells_t cm = '0, cp = '0;
  logic [7:0] din = '0, ioi, ioo, iooe, eo, ex;
  logic [NB-1:0] tm = '0, km = '0;
  logic [63:0] sw = '0, sig;
  logic [10:0] va = '0;
  int n_mismatch = 0, n_tests = 0;
  always #4 clk = ~clk;
  lamc_top dut (.clk, .rst, .register_allow_global(ra),
    .family_select_global(fs), .cell_mode_bit(cm), .cell_polarity_bit(cp),
    .and_true_mask(tm), .and_comp_mask(km), .ded_in(din), .pin1_in(p1),
    .pin11_oe_n(oen), .io_in(ioi), .io_out(ioo), .io_oe(iooe),
    .preload(pre), .prog_erase(pg[3]), .prog_security_set(pg[2]),
    .prog_sig_we(pg[1]), .prog_sig_wdata(sw), .prog_verify_rd(pg[0]),
    .prog_verify_addr(va), .verify_data(vd), .security_bit(sb),
    .signature(sig));
  lamc_board bd (.clk, .io_out(ioo), .io_oe(iooe), .io_in(ioi));
  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Masks touch only the dedicated inputs, so feedback never matters
  function automatic void model(logic [2:0] md);
    logic [7:0] s;
    logic [17:0] v;
    v = {10'h000, din};
    for (int c = 0; c < 8; c++) begin
      for (int i = 0; i < 8; i++)
        s[i] = (&(~tm[(c*8+i)*18 +: 18] | v))
             & (&(~km[(c*8+i)*18 +: 18] | ~v));
      // Preload takes the registered pins off so the tester can drive them
      eo[c] = md == 3'b100 || md[1:0] == 2'b11 && s[7]
           || md == 3'b010 && !oen && !pre;
      ex[c] = eo[c] && ((md[1:0] == 2'b00 || md == 3'b010 ? |s : |s[6:0])
                        ~^ cp[c]);
    end
  endfunction
  task automatic prog(logic [3:0] k);
    @(posedge clk);
    pg <= k;
    @(posedge clk);
    pg <= 4'h0;
    #1;
  endtask
  initial begin
    void'($urandom(10813));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int m = 0; m < 6; m++)
      for (int n = 0; n < 24; n++) begin
        @(posedge clk);
        {ra, fs} <= MD[m][2:1];
        cm <= {8{MD[m][0]}};
        cp <= 8'($urandom);
        din <= 8'($urandom);
        {p1, oen, pre} <= 3'($urandom);
        // First two passes: empty terms, then true-and-complement terms
        for (int r = 0; r < 64; r++) begin
          tm[r*18 +: 18] <= n < 2 ? 18'(8'hff * n) : 18'($urandom & 255);
          km[r*18 +: 18] <= n < 2 ? 18'(8'hff * n)
                          : 18'($urandom & $urandom & $urandom & 255);
        end
        @(posedge clk);
        #1 model(MD[m]);
        chk("io_oe", eo, iooe);
        chk("io_out", ex, ioo & eo);
      end
    @(posedge clk);
    tm <= '1;
    va <= 11'($urandom_range(NB - 1));
    sw <= {$urandom, $urandom};
    prog(4'h1);
    chk("verify_data", 1, vd);
    prog(4'h2);
    chk("signature", sw, sig);
    prog(4'h4);
    chk("security_bit", 1, sb);
    prog(4'h1);
    chk("verify_data", 0, vd);
    chk("signature", sw, sig);
    prog(4'h8);
    chk("security_bit", 0, sb);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    #1 chk("io_oe", 0, iooe);
    conclude();
  end
endmodule
`default_nettype wire
